//--- monitor_pkg.sv
// Shared constants and types for the monitor sequencing block
package monitor_pkg;
    localparam int CHANNEL_COUNT = 5;
    localparam int ZONE_COUNT = 3;
    localparam int FAN_COUNT = 4;
    localparam int PWM_COUNT = 3;
    localparam int CLOCK_MHZ = 250;
    localparam int ROUND_IDLE_MS = 1000;
    localparam int IDLE_CYCLES = ROUND_IDLE_MS * CLOCK_MHZ * 1000;
    localparam int RAMP_STEP_CYCLES_DEFAULT = 1024;
    // Register offsets
    localparam logic [7:0] CONTROL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h01;
    localparam logic [7:0] INT_STATUS_ADDR = 8'h02;
    localparam logic [7:0] INT_ENABLE_ADDR = 8'h03;
    localparam logic [7:0] INT_CLEAR_ADDR = 8'h04;
    localparam logic [7:0] READING_BASE = 8'h10;
    localparam logic [7:0] LIMIT_HIGH_BASE = 8'h18;
    localparam logic [7:0] LIMIT_LOW_BASE = 8'h20;
    localparam logic [7:0] TACH_BASE = 8'h28;
    localparam logic [7:0] TACH_LIMIT_BASE = 8'h2c;
    localparam logic [7:0] PWM_DUTY_BASE = 8'h30;
    localparam logic [7:0] PWM_ZONES_BASE = 8'h34;
    localparam logic [7:0] ZONE_LOW_BASE = 8'h38;
    localparam logic [7:0] RAMP_ADDR = 8'h3c;
    // Control bit positions
    localparam int CTRL_START = 0;
    localparam int CTRL_CYCLE = 1;
    localparam int CTRL_SLEEP = 2;
    localparam int CTRL_SHUTDOWN = 3;
    localparam int CTRL_AUTO = 4;
    localparam int CTRL_RAMP = 5;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] LIMIT_HIGH_RESET = 8'hff;
    localparam logic [7:0] LIMIT_LOW_RESET = 8'h00;
    localparam logic [7:0] ZONE_LOW_RESET = 8'h80;
    localparam logic [7:0] DUTY_RESET = 8'hff;
    // Interrupt status bits
    localparam int INT_VOLT = 0;
    localparam int INT_TEMP = 1;
    localparam int INT_FAN = 2;
    localparam int INT_ROUND = 3;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_CONVERT = 2'b01,
        SEQ_WAIT = 2'b10
    } seq_type;
endpackage

//--- monitor_cycle_power_control.sv
// Monitor round sequencing, power states, limits, fan and interrupt logic
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Contract
// - In continuous mode conversion rounds run back to back.
// - In cycle mode a round is followed by an idle wait of about one second.
// - In cycle mode each channel is converted exactly once per round.
// - Entering sleep or shutdown never alters any register; the code clears the busy bit of the status register.
// - Sleep keeps bias and oscillator on while converter and sequencer stop.
// - In sleep every register stays readable and writable from the host.
// - Shutdown turns off bias, oscillator, converter and sequencer.
// - In shutdown only the control register can be accessed by the host.
// - The active-low interrupt asserts on out-of-limit temperature or voltage.
// - Each fan tachometer reading is compared with its stored limit.
// - In automatic mode duty follows zone temperature and limits without the host.
// - Each PWM may be linked to any set of zones and follows the hottest linked zone.
// - With automatic mode and ramp control both on, duty moves at most one step per ramp interval.
module monitor_cycle_power_control #(
    parameter int IDLE_CYCLES = monitor_pkg::IDLE_CYCLES,
    parameter int RAMP_STEP_CYCLES = monitor_pkg::RAMP_STEP_CYCLES_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regReadData,
    output logic convertStart,
    output logic [2:0] convertChannel,
    input wire logic convertDone,
    input wire logic [7:0] convertResult,
    input wire logic [7:0] tachCount0,
    input wire logic [7:0] tachCount1,
    input wire logic [7:0] tachCount2,
    input wire logic [7:0] tachCount3,
    output logic biasEnable,
    output logic oscEnable,
    output logic converterEnable,
    output logic [7:0] pwmDuty0,
    output logic [7:0] pwmDuty1,
    output logic [7:0] pwmDuty2,
    output logic interrupt_n
);
    //////////////////////////////////////////////////////////////////////////
    logic [7:0] control;
    logic [7:0] reading [monitor_pkg::CHANNEL_COUNT];
    logic [7:0] limitHigh [monitor_pkg::CHANNEL_COUNT];
    logic [7:0] limitLow [monitor_pkg::CHANNEL_COUNT];
    logic [7:0] tachLimit [monitor_pkg::FAN_COUNT];
    logic [7:0] tach [monitor_pkg::FAN_COUNT];
    logic [7:0] duty [monitor_pkg::PWM_COUNT];
    logic [7:0] hostDuty [monitor_pkg::PWM_COUNT];
    logic [2:0] zoneLink [monitor_pkg::PWM_COUNT];
    logic [7:0] zoneLow [monitor_pkg::ZONE_COUNT];
    logic [7:0] tachSync1 [monitor_pkg::FAN_COUNT];
    logic [7:0] tachSync2 [monitor_pkg::FAN_COUNT];
    logic [7:0] tachHold [monitor_pkg::FAN_COUNT];
    logic [3:0] intStatus;
    logic [3:0] intEnable;
    logic [3:0] intSet;
    monitor_pkg::seq_type state;
    logic [2:0] channel;
    logic busy;
    logic [31:0] waitCount;
    logic [31:0] rampCount;
    logic rampTick;
    logic lowPower;
    logic shutdown;
    logic accessOk;
    logic [7:0] target [monitor_pkg::PWM_COUNT];

    function automatic logic outOfLimit(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
        outOfLimit = (v > hi) || (v < lo);
    endfunction

    function automatic logic inRange(input logic [7:0] a, input logic [7:0] base,
                                     input int n);
        inRange = (a >= base) && (a < base + 8'(n));
    endfunction

    function automatic logic [7:0] zoneDuty(input logic [7:0] temp, input logic [7:0] low);
        zoneDuty = (temp <= low) ? 8'h00 : (temp - low > 8'h7f) ? 8'hff : 8'((temp - low) << 1);
    endfunction

    assign shutdown = control[monitor_pkg::CTRL_SHUTDOWN];
    assign lowPower = shutdown || control[monitor_pkg::CTRL_SLEEP];
    assign biasEnable = !shutdown;
    assign oscEnable = !shutdown;
    assign converterEnable = !lowPower;
    // Shutdown admits only the control register so the host can wake it
    assign accessOk = !shutdown || (regAddr == monitor_pkg::CONTROL_ADDR);
    assign convertChannel = channel;
    assign pwmDuty0 = duty[0];
    assign pwmDuty1 = duty[1];
    assign pwmDuty2 = duty[2];

    //////////////////////////////////////////////////////////////////////////
    // Tach inputs come from a foreign domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < monitor_pkg::FAN_COUNT; i++) begin
                tachSync1[i] <= 8'h00;
                tachSync2[i] <= 8'h00;
            end
        end else begin
            tachSync1[0] <= tachCount0;
            tachSync1[1] <= tachCount1;
            tachSync1[2] <= tachCount2;
            tachSync1[3] <= tachCount3;
            tachSync2 <= tachSync1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < monitor_pkg::FAN_COUNT; i++) begin
                tach[i] <= 8'h00;
                tachHold[i] <= 8'h00;
            end
        end else if (!lowPower) begin
            // Take a word only once two samples agree
            tachHold <= tachSync2;
            for (int i = 0; i < monitor_pkg::FAN_COUNT; i++) begin
                if (tachSync2[i] == tachHold[i]) begin
                    tach[i] <= tachSync2[i];
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Round sequencer; low power parks it and reissues the open conversion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= monitor_pkg::SEQ_IDLE;
            channel <= 3'h0;
            busy <= 1'b0;
            waitCount <= 32'h0;
            convertStart <= 1'b0;
        end else begin
            convertStart <= 1'b0;
            if (lowPower) begin
                busy <= 1'b0;
            end else begin
                case (state)
                    monitor_pkg::SEQ_IDLE: begin
                        channel <= 3'h0;
                        if (control[monitor_pkg::CTRL_START]) begin
                            state <= monitor_pkg::SEQ_CONVERT;
                        end
                    end
                    monitor_pkg::SEQ_CONVERT: begin
                        if (!busy) begin
                            convertStart <= 1'b1;
                            busy <= 1'b1;
                        end else if (convertDone) begin
                            busy <= 1'b0;
                            if (channel == 3'(monitor_pkg::CHANNEL_COUNT - 1)) begin
                                channel <= 3'h0;
                                if (!control[monitor_pkg::CTRL_START]) begin
                                    state <= monitor_pkg::SEQ_IDLE;
                                end else if (control[monitor_pkg::CTRL_CYCLE]) begin
                                    state <= monitor_pkg::SEQ_WAIT;
                                    waitCount <= 32'(IDLE_CYCLES - 1);
                                end
                                // Continuous mode restarts at once
                            end else begin
                                channel <= channel + 3'h1;
                            end
                        end
                    end
                    monitor_pkg::SEQ_WAIT: begin
                        if (waitCount == 32'h0) begin
                            state <= monitor_pkg::SEQ_IDLE;
                        end else begin
                            waitCount <= waitCount - 32'h1;
                        end
                    end
                    default: state <= monitor_pkg::SEQ_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < monitor_pkg::CHANNEL_COUNT; i++) begin
                reading[i] <= 8'h00;
            end
        end else if (state == monitor_pkg::SEQ_CONVERT && busy && convertDone && !lowPower) begin
            reading[channel] <= convertResult;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Host registers; power state changes never touch them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control <= monitor_pkg::CONTROL_RESET;
            intEnable <= 4'h0;
            for (int i = 0; i < monitor_pkg::CHANNEL_COUNT; i++) begin
                limitHigh[i] <= monitor_pkg::LIMIT_HIGH_RESET;
                limitLow[i] <= monitor_pkg::LIMIT_LOW_RESET;
            end
            for (int i = 0; i < monitor_pkg::FAN_COUNT; i++) begin
                tachLimit[i] <= 8'h00;
            end
            for (int i = 0; i < monitor_pkg::PWM_COUNT; i++) begin
                hostDuty[i] <= monitor_pkg::DUTY_RESET;
                zoneLink[i] <= 3'h0;
            end
            for (int i = 0; i < monitor_pkg::ZONE_COUNT; i++) begin
                zoneLow[i] <= monitor_pkg::ZONE_LOW_RESET;
            end
        end else if (regWrite && accessOk) begin
            if (regAddr == monitor_pkg::CONTROL_ADDR) begin
                control <= regWriteData;
            end else if (regAddr == monitor_pkg::INT_ENABLE_ADDR) begin
                intEnable <= regWriteData[3:0];
            end else if (inRange(regAddr, monitor_pkg::LIMIT_HIGH_BASE, 5)) begin
                limitHigh[3'(regAddr - monitor_pkg::LIMIT_HIGH_BASE)] <= regWriteData;
            end else if (inRange(regAddr, monitor_pkg::LIMIT_LOW_BASE, 5)) begin
                limitLow[3'(regAddr - monitor_pkg::LIMIT_LOW_BASE)] <= regWriteData;
            end else if (inRange(regAddr, monitor_pkg::TACH_LIMIT_BASE, 4)) begin
                tachLimit[2'(regAddr - monitor_pkg::TACH_LIMIT_BASE)] <= regWriteData;
            end else if (inRange(regAddr, monitor_pkg::PWM_DUTY_BASE, 3)) begin
                hostDuty[2'(regAddr - monitor_pkg::PWM_DUTY_BASE)] <= regWriteData;
            end else if (inRange(regAddr, monitor_pkg::PWM_ZONES_BASE, 3)) begin
                zoneLink[2'(regAddr - monitor_pkg::PWM_ZONES_BASE)] <= regWriteData[2:0];
            end else if (inRange(regAddr, monitor_pkg::ZONE_LOW_BASE, 3)) begin
                zoneLow[2'(regAddr - monitor_pkg::ZONE_LOW_BASE)] <= regWriteData;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regReadData <= 8'h00;
        end else if (regRead && accessOk) begin
            regReadData <= 8'h00;
            if (regAddr == monitor_pkg::CONTROL_ADDR) begin
                regReadData <= control;
            end else if (regAddr == monitor_pkg::STATUS_ADDR) begin
                regReadData <= {3'h0, busy, channel, state != monitor_pkg::SEQ_IDLE};
            end else if (regAddr == monitor_pkg::INT_STATUS_ADDR) begin
                regReadData <= {4'h0, intStatus};
            end else if (regAddr == monitor_pkg::INT_ENABLE_ADDR) begin
                regReadData <= {4'h0, intEnable};
            end else if (inRange(regAddr, monitor_pkg::READING_BASE, 5)) begin
                regReadData <= reading[3'(regAddr - monitor_pkg::READING_BASE)];
            end else if (inRange(regAddr, monitor_pkg::LIMIT_HIGH_BASE, 5)) begin
                regReadData <= limitHigh[3'(regAddr - monitor_pkg::LIMIT_HIGH_BASE)];
            end else if (inRange(regAddr, monitor_pkg::LIMIT_LOW_BASE, 5)) begin
                regReadData <= limitLow[3'(regAddr - monitor_pkg::LIMIT_LOW_BASE)];
            end else if (inRange(regAddr, monitor_pkg::TACH_BASE, 4)) begin
                regReadData <= tach[2'(regAddr - monitor_pkg::TACH_BASE)];
            end else if (inRange(regAddr, monitor_pkg::TACH_LIMIT_BASE, 4)) begin
                regReadData <= tachLimit[2'(regAddr - monitor_pkg::TACH_LIMIT_BASE)];
            end else if (inRange(regAddr, monitor_pkg::PWM_DUTY_BASE, 3)) begin
                regReadData <= duty[2'(regAddr - monitor_pkg::PWM_DUTY_BASE)];
            end else if (inRange(regAddr, monitor_pkg::PWM_ZONES_BASE, 3)) begin
                regReadData <= {5'h00, zoneLink[2'(regAddr - monitor_pkg::PWM_ZONES_BASE)]};
            end else if (inRange(regAddr, monitor_pkg::ZONE_LOW_BASE, 3)) begin
                regReadData <= zoneLow[2'(regAddr - monitor_pkg::ZONE_LOW_BASE)];
            end
        end else begin
            regReadData <= 8'h00;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Events: channels 0-1 are voltages, 2-4 temperatures
    always_comb begin
        intSet = 4'h0;
        for (int i = 0; i < monitor_pkg::CHANNEL_COUNT; i++) begin
            if (outOfLimit(reading[i], limitLow[i], limitHigh[i])) begin
                intSet[(i < 2) ? monitor_pkg::INT_VOLT : monitor_pkg::INT_TEMP] = 1'b1;
            end
        end
        for (int i = 0; i < monitor_pkg::FAN_COUNT; i++) begin
            // A slow fan yields a large period count
            if (tach[i] > tachLimit[i]) begin
                intSet[monitor_pkg::INT_FAN] = 1'b1;
            end
        end
        if (state == monitor_pkg::SEQ_CONVERT && busy && convertDone && !lowPower
            && channel == 3'(monitor_pkg::CHANNEL_COUNT - 1)) begin
            intSet[monitor_pkg::INT_ROUND] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intStatus <= 4'h0;
        end else begin
            // Set wins over a clear in the same cycle
            if (regWrite && accessOk && regAddr == monitor_pkg::INT_CLEAR_ADDR) begin
                intStatus <= (intStatus & ~regWriteData[3:0]) | intSet;
            end else begin
                intStatus <= intStatus | intSet;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_n <= 1'b1;
        end else begin
            interrupt_n <= !(|(intStatus & intEnable));
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Zone targets: hottest linked zone wins
    always_comb begin
        for (int p = 0; p < monitor_pkg::PWM_COUNT; p++) begin
            target[p] = 8'h00;
            for (int z = 0; z < monitor_pkg::ZONE_COUNT; z++) begin
                if (zoneLink[p][z] && zoneDuty(reading[z + 2], zoneLow[z]) > target[p]) begin
                    target[p] = zoneDuty(reading[z + 2], zoneLow[z]);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rampCount <= 32'h0;
            rampTick <= 1'b0;
        end else begin
            rampTick <= (rampCount == 32'h0);
            rampCount <= (rampCount == 32'h0) ? 32'(RAMP_STEP_CYCLES - 1) : rampCount - 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int p = 0; p < monitor_pkg::PWM_COUNT; p++) begin
                duty[p] <= monitor_pkg::DUTY_RESET;
            end
        end else begin
            for (int p = 0; p < monitor_pkg::PWM_COUNT; p++) begin
                if (!control[monitor_pkg::CTRL_AUTO]) begin
                    duty[p] <= hostDuty[p];
                end else if (!control[monitor_pkg::CTRL_RAMP]) begin
                    duty[p] <= target[p];
                end else if (rampTick && duty[p] < target[p]) begin
                    duty[p] <= duty[p] + 8'h01;
                end else if (rampTick && duty[p] > target[p]) begin
                    duty[p] <= duty[p] - 8'h01;
                end
            end
        end
    end
endmodule // monitor_cycle_power_control

//--- converter_model.sv
// Behavioural converter answering each conversion request
`timescale 1ns/1ps
module converter_model #(
    parameter int DELAY = 3
) (
    input wire logic clk,
    input wire logic slow,
    input wire logic convertStart,
    input wire logic [2:0] convertChannel,
    output logic convertDone,
    output logic [7:0] convertResult
);
    int count = 0;
    logic [2:0] held = 3'h0;
    initial begin
        convertDone = 1'b0;
        convertResult = 8'h00;
    end
    // Toggling result exposes a stale read
    always @(posedge clk) begin
        convertDone <= 1'b0;
        convertResult <= ~convertResult;
        if (convertStart) begin
            count <= slow ? 20 : DELAY;
            held <= convertChannel;
        end else if (count == 1) begin
            convertDone <= 1'b1;
            convertResult <= 8'h40 + {5'h00, held};
        end
        if (!convertStart && count > 0) count <= count - 1;
    end
endmodule // converter_model

//--- monitor_cycle_power_control_props.sv
// Port checker for the monitor sequencing block
`timescale 1ns/1ps
module monitor_cycle_power_control_props #(
    parameter int IDLE_CYCLES = 50,
    parameter int RAMP_STEP_CYCLES = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regReadData,
    input wire logic convertStart,
    input wire logic [2:0] convertChannel,
    input wire logic biasEnable,
    input wire logic oscEnable,
    input wire logic converterEnable,
    input wire logic [7:0] pwmDuty0,
    input wire logic interrupt_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] control;
    logic [2:0] lastChannel;
    logic started;
    logic rampOn;
    int gap;
    assign rampOn = control[4] && control[5];
    ////////////////////////////////////////
    // Control shadow; writable in every power state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control <= monitor_pkg::CONTROL_RESET;
            lastChannel <= 3'h0;
            started <= 1'b0;
            gap <= 0;
        end else begin
            if (regWrite && regAddr == monitor_pkg::CONTROL_ADDR) control <= regWriteData;
            gap <= convertStart ? 0 : gap + 1;
            if (convertStart) lastChannel <= convertChannel;
            if (convertStart) started <= 1'b1;
        end
    end
    ////////////////////////////////////////
    a_power_rails: assert property (
        regWrite && regAddr == monitor_pkg::CONTROL_ADDR
        |=> biasEnable == !$past(regWriteData[3]) && oscEnable == biasEnable)
        else $error("rail enable wrong");
    a_converter_gate: assert property (
        regWrite && regAddr == monitor_pkg::CONTROL_ADDR
        |=> converterEnable == !(|$past(regWriteData[3:2])))
        else $error("converter enable wrong");
    a_read_idle: assert property (!regRead |=> regReadData == 8'h00)
        else $error("stale read data");
    a_shutdown_refuse: assert property (
        control[3] && regRead && regAddr != monitor_pkg::CONTROL_ADDR |=> regReadData == 8'h00)
        else $error("shutdown access");
    a_start_pulse: assert property (convertStart |=> !convertStart)
        else $error("long start");
    a_asleep_quiet: assert property (
        !converterEnable && !$past(converterEnable) |-> !convertStart)
        else $error("conversion while stopped");
    a_channel_range: assert property (convertStart |-> convertChannel <= 3'h4)
        else $error("channel out of range");
    a_channel_order: assert property (
        convertStart && started |-> convertChannel == lastChannel
        || convertChannel == (lastChannel == 3'h4 ? 3'h0 : lastChannel + 3'h1))
        else $error("channel order broken");
    a_cycle_wait: assert property (
        convertStart && started && lastChannel == 3'h4 && control[1] |-> gap >= IDLE_CYCLES)
        else $error("round too soon");
    a_mask_release: assert property (
        regWrite && regAddr == monitor_pkg::INT_ENABLE_ADDR && regWriteData == 8'h00
        |-> ##3 interrupt_n)
        else $error("masked interrupt");
    a_host_duty: assert property (
        regWrite && regAddr == monitor_pkg::PWM_DUTY_BASE && !control[4]
        |-> ##3 pwmDuty0 == $past(regWriteData, 3))
        else $error("host duty");
    a_ramp_step: assert property (
        rampOn && $past(rampOn) |-> pwmDuty0 == $past(pwmDuty0)
        || pwmDuty0 == $past(pwmDuty0) + 8'h01 || pwmDuty0 == $past(pwmDuty0) - 8'h01)
        else $error("ramp step");
endmodule // monitor_cycle_power_control_props
bind monitor_cycle_power_control monitor_cycle_power_control_props #(
    .IDLE_CYCLES(IDLE_CYCLES), .RAMP_STEP_CYCLES(RAMP_STEP_CYCLES)) props (
    .clk, .rst_n, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData, .convertStart,
    .convertChannel, .biasEnable, .oscEnable, .converterEnable, .pwmDuty0, .interrupt_n);

//--- monitor_cycle_power_control_tb.sv
// Self-checking testbench for the monitor sequencing block
`timescale 1ns/1ps
module monitor_cycle_power_control_tb;
    logic clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, slow = 1'b0, measure = 1'b0;
    logic [7:0] regAddr = 8'h00, regWriteData = 8'h00, tachCount0 = 8'h00;
    logic [7:0] tachCount1 = 8'h00, tachCount2 = 8'h00, tachCount3 = 8'h00;
    logic convertStart, convertDone, biasEnable, oscEnable, converterEnable, interrupt_n;
    logic [2:0] convertChannel;
    logic [7:0] regReadData, convertResult, pwmDuty0, pwmDuty1, pwmDuty2;
    logic [7:0] resetAddr [6] = '{8'h00, 8'h18, 8'h20, 8'h38, 8'h30, 8'h3c};
    logic [7:0] resetVal [6] = '{8'h00, 8'hff, 8'h00, 8'h80, 8'hff, 8'h00};
    int failures = 0, numChecks = 0, gap = 0, maxGap = 0, starts = 0, rounds = 0, i;
    initial begin
        forever #2 clk = ~clk;
    end
    monitor_cycle_power_control #(.IDLE_CYCLES(50), .RAMP_STEP_CYCLES(4)) dut (
        .clk, .rst_n, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData, .convertStart,
        .convertChannel, .convertDone, .convertResult, .tachCount0, .tachCount1, .tachCount2,
        .tachCount3, .biasEnable, .oscEnable, .converterEnable, .pwmDuty0, .pwmDuty1,
        .pwmDuty2, .interrupt_n);
    converter_model conv (.clk, .slow, .convertStart, .convertChannel, .convertDone,
        .convertResult);
    ////////////////////////////////////////
    always @(posedge clk) begin
        gap <= convertStart ? 0 : gap + 1;
        if (!measure) begin
            maxGap <= 0;
            starts <= 0;
            rounds <= 0;
        end else begin
            if (gap > maxGap) maxGap <= gap;
            if (convertStart) starts <= starts + 1;
            if (convertStart && convertChannel == 3'h0) rounds <= rounds + 1;
        end
    end
    task automatic summarize;
        if (failures == 0 && numChecks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] exp, got);
        numChecks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic settle(input bit ok, input string name);
        check(name, 8'h01, {7'h00, ok});
        if (!ok) summarize();
    endtask
    task automatic regWr(input logic [7:0] a, d);
        @(posedge clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic regRd(input logic [7:0] a, mask, exp);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 check($sformatf("reg %h", a), exp, regReadData & mask);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 6; i++) regRd(resetAddr[i], 8'hff, resetVal[i]);
        regWr(8'h18, 8'h20);
        regWr(8'h03, 8'h01);
        regWr(8'h00, 8'h01);
        for (i = 0; i < 300 && interrupt_n !== 1'b0; i++) @(posedge clk);
        settle(interrupt_n === 1'b0, "interrupt_n");
        regRd(8'h02, 8'h01, 8'h01);
        measure <= 1'b1;
        repeat (100) @(posedge clk);
        check("starts", 8'h01, {7'h00, starts >= 10});
        check("maxGap", 8'h01, {7'h00, maxGap <= 9});
        for (i = 0; i < 5; i++) regRd(8'h10 + i[7:0], 8'hff, 8'h40 + i[7:0]);
        measure <= 1'b0;
        regWr(8'h03, 8'h00);
        repeat (3) @(posedge clk);
        #1 check("interrupt_n", 8'h01, {7'h00, interrupt_n});
        regWr(8'h18, 8'hff);
        regWr(8'h04, 8'h0f);
        regRd(8'h02, 8'h01, 8'h00);
        regRd(8'h04, 8'hff, 8'h00);
        regWr(8'h2c, 8'h60);
        tachCount0 <= 8'h70;
        repeat (4) @(posedge clk);
        regWr(8'h04, 8'h0f);
        regRd(8'h02, 8'h04, 8'h04);
        regRd(8'h28, 8'hff, 8'h70);
        tachCount0 <= 8'h50;
        repeat (4) @(posedge clk);
        regWr(8'h04, 8'h0f);
        regRd(8'h02, 8'h04, 8'h00);
        regWr(8'h00, 8'h05);
        #1 check("power", 8'h03, {5'h00, converterEnable, biasEnable, oscEnable});
        regWr(8'h19, 8'h77);
        regRd(8'h19, 8'hff, 8'h77);
        regRd(8'h2c, 8'hff, 8'h60);
        regWr(8'h00, 8'h09);
        #1 check("power", 8'h00, {5'h00, converterEnable, biasEnable, oscEnable});
        regRd(8'h19, 8'hff, 8'h00);
        regWr(8'h19, 8'h11);
        regRd(8'h00, 8'hff, 8'h09);
        regWr(8'h00, 8'h01);
        regRd(8'h19, 8'hff, 8'h77);
        regWr(8'h30, 8'h5a);
        repeat (3) @(posedge clk);
        #1 check("pwmDuty0", 8'h5a, pwmDuty0);
        regRd(8'h30, 8'hff, 8'h5a);
        regWr(8'h34, 8'h01);
        regWr(8'h35, 8'h00);
        regWr(8'h36, 8'h07);
        regWr(8'h38, 8'h30);
        regWr(8'h00, 8'h31);
        repeat (20) @(posedge clk);
        #1 check("ramp", 8'h01, {7'h00, pwmDuty1 > 8'hf0});
        for (i = 0; i < 3000 && pwmDuty1 !== 8'h00; i++) @(posedge clk);
        #1 settle(pwmDuty1 === 8'h00, "pwmDuty1");
        check("pwmDuty0", 8'h24, pwmDuty0);
        check("pwmDuty2", 8'h24, pwmDuty2);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        check("pwmDuty0", 8'hff, pwmDuty0);
        rst_n <= 1'b1;
        regRd(8'h38, 8'hff, 8'h80);
        slow <= 1'b1;
        measure <= 1'b1;
        regWr(8'h00, 8'h03);
        for (i = 0; i < 2000 && !(rounds == 2 && gap == 30); i++) @(posedge clk);
        settle(rounds == 2 && gap == 30, "rounds");
        check("starts", 8'h0a, starts[7:0]);
        check("maxGap", 8'h01, {7'h00, maxGap >= 50});
        summarize();
    end
endmodule // monitor_cycle_power_control_tb
